// [lscd_top.sv]
// status pin clock dividers with prescalers, pin muxes and edge rate
// assumes both pll clocks are far below half of clk_i; they are sampled
// a divider taken off code zero restarts by itself, no software restart needed
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "lscd_defs.svh"

// What this block does
// RULE1: divider A is an 8-bit programmable divider fed by the first pll prescaler.
// RULE2: divider A maps code 6 to ratio 7 and each higher code N to N+1, up to 256.
// RULE3: codes 1 to 5 on either divider all give ratio 6.
// RULE4: code zero on divider A stops it so it gives no clock.
// RULE5: software restarts a divider after taking it from stopped to running; here a divider restarts by itself once its code leaves zero.
// RULE6: divider B is an 8-bit divider fed by the second pll prescaler.
// RULE7: divider B uses the same code to ratio mapping as divider A.
// RULE8: code zero on divider B stops it and its clock.
// RULE9: bits 3:2 of the slew register set pin B edge rate, 0 fast, 2 slow.
// RULE10: bits 1:0 of the slew register set pin A edge rate, 0 fast, 2 slow.
// RULE11: prescale select 0 stops, 1 divides by 4, 2 by 5, 3 is reserved.
// RULE12: pin source 0 is divider A, 1 divider B, 2 normal status, 3 off.
// RULE13: an enabled divider gives one output period per N input periods.
module lscd_top #(
	// pll synchroniser depth ahead of the edge detector
	parameter int SYNC_STAGES = 2
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// register port
	input  wire logic [7:0]        addr_i,
	input  wire logic [7:0]        wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [7:0]        rdata_o,
	// pll clocks, asynchronous to clk_i
	input  wire logic              first_pll_clk_i,
	input  wire logic              second_pll_clk_i,
	// normal status levels from device logic
	input  wire logic              status_a_normal_i,
	input  wire logic              status_b_normal_i,
	// status pins
	output lscd_pkg::lscd_pin_t    status_pin_a_o,
	output lscd_pkg::lscd_pin_t    status_pin_b_o
);

	// register state
	lscd_pkg::lscd_ctrl_t ctrl_reg;
	lscd_pkg::lscd_ctrl_t ctrl_next;
	logic [7:0]           diva_reg;
	logic [7:0]           diva_next;
	logic [7:0]           divb_reg;
	logic [7:0]           divb_next;
	logic [`LSCD_SLEW_W-1:0] slew_reg;
	logic [`LSCD_SLEW_W-1:0] slew_next;
	logic                 rst_a_reg;
	logic                 rst_a_next;
	logic                 rst_b_reg;
	logic                 rst_b_next;
	logic [7:0]           rdata_reg;
	logic [7:0]           rdata_next;

	// synchronisers and edge detect
	logic [SYNC_STAGES:0] sync_a_reg;
	logic [SYNC_STAGES:0] sync_a_next;
	logic [SYNC_STAGES:0] sync_b_reg;
	logic [SYNC_STAGES:0] sync_b_next;
	logic                 edge_a;
	logic                 edge_b;

	// prescalers
	logic [2:0]           pre_a_cnt_reg;
	logic [2:0]           pre_a_cnt_next;
	logic [2:0]           pre_b_cnt_reg;
	logic [2:0]           pre_b_cnt_next;
	logic                 tick_a_reg;
	logic                 tick_a_next;
	logic                 tick_b_reg;
	logic                 tick_b_next;
	logic [2:0]           pre_a_len;
	logic [2:0]           pre_b_len;

	// dividers and pins
	logic                 diva_clk;
	logic                 divb_clk;
	logic                 diva_act;
	logic                 divb_act;
	logic [7:0]           state_word;
	lscd_pkg::lscd_pin_t  pin_a_reg;
	lscd_pkg::lscd_pin_t  pin_a_next;
	lscd_pkg::lscd_pin_t  pin_b_reg;
	lscd_pkg::lscd_pin_t  pin_b_next;

	// register writes and restart pulses
	always_comb begin
		ctrl_next  = ctrl_reg;
		diva_next  = diva_reg;
		divb_next  = divb_reg;
		slew_next  = slew_reg;
		rst_a_next = 1'b0;
		rst_b_next = 1'b0;
		if (wr_i) begin
			case (addr_i)
				`LSCD_ADDR_CTRL:    ctrl_next = wdata_i;
				`LSCD_ADDR_DIVA:    diva_next = wdata_i; // see RULE1
				`LSCD_ADDR_DIVB:    divb_next = wdata_i; // see RULE6
				// reserved codes are stored as written, drive as fast
				`LSCD_ADDR_SLEW:    slew_next = wdata_i[`LSCD_SLEW_W-1:0];
				`LSCD_ADDR_RESTART: begin
					rst_a_next = wdata_i[`LSCD_RST_BIT_A]; // see RULE5
					rst_b_next = wdata_i[`LSCD_RST_BIT_B]; // see RULE5
				end
				default: ;
			endcase
		end
	end

	// live divider and prescaler state; upper bits read zero
	always_comb begin
		state_word                 = 8'h00;
		state_word[`LSCD_ST_ACT_A] = diva_act;
		state_word[`LSCD_ST_ACT_B] = divb_act;
		state_word[`LSCD_ST_CLK_A] = diva_clk;
		state_word[`LSCD_ST_CLK_B] = divb_clk;
		state_word[`LSCD_ST_PRE_A] = (pre_a_len != `LSCD_PRE_LEN0);
		state_word[`LSCD_ST_PRE_B] = (pre_b_len != `LSCD_PRE_LEN0);
	end

	// read data valid the cycle after the strobe only
	always_comb begin
		rdata_next = 8'h00;
		if (rd_i) begin
			case (addr_i)
				`LSCD_ADDR_CTRL:  rdata_next = ctrl_reg;
				`LSCD_ADDR_DIVA:  rdata_next = diva_reg;
				`LSCD_ADDR_DIVB:  rdata_next = divb_reg;
				`LSCD_ADDR_SLEW:  rdata_next = {4'h0, slew_reg};
				`LSCD_ADDR_STATE: rdata_next = state_word;
				// write-only restart and unmapped addresses read zero
				default:          rdata_next = 8'h00;
			endcase
		end
	end

	// restart bits are one-cycle pulses; a held bit would pin a divider
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_reg  <= `LSCD_CTRL_RST;
			diva_reg  <= `LSCD_DIV_RST;
			divb_reg  <= `LSCD_DIV_RST;
			slew_reg  <= `LSCD_SLEW_RST;
			rst_a_reg <= 1'b0;
			rst_b_reg <= 1'b0;
		end else begin
			ctrl_reg  <= ctrl_next;
			diva_reg  <= diva_next;
			divb_reg  <= divb_next;
			slew_reg  <= slew_next;
			rst_a_reg <= rst_a_next;
			rst_b_reg <= rst_b_next;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// sync stages first, last stage only for the edge detector
	always_comb begin
		sync_a_next = {sync_a_reg[SYNC_STAGES-1:0], first_pll_clk_i};
		sync_b_next = {sync_b_reg[SYNC_STAGES-1:0], second_pll_clk_i};
		edge_a      = sync_a_reg[SYNC_STAGES-1]
			& ~sync_a_reg[SYNC_STAGES];
		edge_b      = sync_b_reg[SYNC_STAGES-1]
			& ~sync_b_reg[SYNC_STAGES];
	end

	// reset level matches an idle low pll clock, so no false edge
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
		end else begin
			sync_a_reg <= sync_a_next;
			sync_b_reg <= sync_b_next;
		end
	end

	// prescalers give one tick per 4 or 5 pll edges
	always_comb begin
		pre_a_len      = lscd_pkg::lscd_prescale(ctrl_reg.pre_a); // see RULE11
		pre_b_len      = lscd_pkg::lscd_prescale(ctrl_reg.pre_b); // see RULE11
		pre_a_cnt_next = pre_a_cnt_reg;
		pre_b_cnt_next = pre_b_cnt_reg;
		tick_a_next    = 1'b0;
		tick_b_next    = 1'b0;
		if (pre_a_len == `LSCD_PRE_LEN0) begin
			pre_a_cnt_next = 3'h0;
		end else if (edge_a) begin
			if (pre_a_cnt_reg >= pre_a_len - 3'h1) begin
				pre_a_cnt_next = 3'h0;
				tick_a_next    = 1'b1;
			end else begin
				pre_a_cnt_next = pre_a_cnt_reg + 3'h1;
			end
		end
		if (pre_b_len == `LSCD_PRE_LEN0) begin
			pre_b_cnt_next = 3'h0;
		end else if (edge_b) begin
			if (pre_b_cnt_reg >= pre_b_len - 3'h1) begin
				pre_b_cnt_next = 3'h0;
				tick_b_next    = 1'b1;
			end else begin
				pre_b_cnt_next = pre_b_cnt_reg + 3'h1;
			end
		end
	end

	// tick registered so each divider sees a clean one-cycle pulse
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre_a_cnt_reg <= 3'h0;
			pre_b_cnt_reg <= 3'h0;
			tick_a_reg    <= 1'b0;
			tick_b_reg    <= 1'b0;
		end else begin
			pre_a_cnt_reg <= pre_a_cnt_next;
			pre_b_cnt_reg <= pre_b_cnt_next;
			tick_a_reg    <= tick_a_next;
			tick_b_reg    <= tick_b_next;
		end
	end

	// divider A on the first pll prescaler, see RULE1 RULE2 RULE3 RULE4
	lscd_divider i_lscd_divider_a (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.code_i    (diva_reg),
		.restart_i (rst_a_reg),
		.tick_i    (tick_a_reg),
		.clk_o     (diva_clk),
		.active_o  (diva_act)
	); // see RULE13

	// divider B on the second pll prescaler, see RULE6 RULE7 RULE8
	lscd_divider i_lscd_divider_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.code_i    (divb_reg),
		.restart_i (rst_b_reg),
		.tick_i    (tick_b_reg),
		.clk_o     (divb_clk),
		.active_o  (divb_act)
	); // see RULE13

	// one pin from its source code, edge rate field and candidates
	function automatic lscd_pkg::lscd_pin_t lscd_pin_pick(
		input logic [1:0] src,
		input logic [1:0] rate,
		input logic       normal,
		input logic       clk_a,
		input logic       clk_b
	);
		lscd_pkg::lscd_pin_t pin;
		pin       = '0;
		pin.drive = 1'b1;
		case (src) // see RULE12
			`LSCD_MUX_DIVA: pin.level = clk_a;
			`LSCD_MUX_DIVB: pin.level = clk_b;
			`LSCD_MUX_NORM: pin.level = normal;
			// source off releases the pad and parks the level low
			default:        pin.drive = 1'b0;
		endcase
		// reserved rate codes fall back to fast edges
		pin.slow = (rate == `LSCD_SLEW_SLOW); // see RULE9 RULE10
		return pin;
	endfunction : lscd_pin_pick

	// pin source select and edge rate
	always_comb begin
		pin_a_next = lscd_pin_pick(ctrl_reg.mux_a,
			slew_reg[`LSCD_SLEW_A_HI:`LSCD_SLEW_A_LO],
			status_a_normal_i, diva_clk, divb_clk); // see RULE10
		pin_b_next = lscd_pin_pick(ctrl_reg.mux_b,
			slew_reg[`LSCD_SLEW_B_HI:`LSCD_SLEW_B_LO],
			status_b_normal_i, diva_clk, divb_clk); // see RULE9
	end

	// pins released and low through reset, one cycle behind dividers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pin_a_reg <= '0;
			pin_b_reg <= '0;
		end else begin
			pin_a_reg <= pin_a_next;
			pin_b_reg <= pin_b_next;
		end
	end

	assign rdata_o        = rdata_reg;
	assign status_pin_a_o = pin_a_reg;
	assign status_pin_b_o = pin_b_reg;

endmodule : lscd_top

// [lscd_defs.svh]
// constants for the status pin clock dividers: offsets, fields, codes
// assumes the register port carries 8-bit addresses and 8-bit data
`ifndef LSCD_DEFS_SVH
`define LSCD_DEFS_SVH

// register offsets
`define LSCD_ADDR_CTRL     8'h2d
`define LSCD_ADDR_DIVA     8'h2e
`define LSCD_ADDR_DIVB     8'h2f
`define LSCD_ADDR_SLEW     8'h31
`define LSCD_ADDR_RESTART  8'h40
`define LSCD_ADDR_STATE    8'h41

// reset values
`define LSCD_CTRL_RST      8'h0a
`define LSCD_DIV_RST       8'h00
`define LSCD_SLEW_RST      4'h0

// slew register fields
`define LSCD_SLEW_B_HI     3
`define LSCD_SLEW_B_LO     2
`define LSCD_SLEW_A_HI     1
`define LSCD_SLEW_A_LO     0
`define LSCD_SLEW_W        4
`define LSCD_SLEW_FAST     2'h0
`define LSCD_SLEW_SLOW     2'h2

// source select codes
`define LSCD_MUX_DIVA      2'h0
`define LSCD_MUX_DIVB      2'h1
`define LSCD_MUX_NORM      2'h2
`define LSCD_MUX_OFF       2'h3

// prescale select codes and lengths
`define LSCD_PRE_OFF       2'h0
`define LSCD_PRE_DIV4      2'h1
`define LSCD_PRE_DIV5      2'h2
`define LSCD_PRE_LEN4      3'h4
`define LSCD_PRE_LEN5      3'h5
`define LSCD_PRE_LEN0      3'h0

// ratio code mapping
`define LSCD_CODE_OFF      8'h00
`define LSCD_CODE_SHORT    8'h05
`define LSCD_RATIO_MIN     9'h006
`define LSCD_RATIO_OFF     9'h000

// restart and state register bits
`define LSCD_RST_BIT_A     0
`define LSCD_RST_BIT_B     1
`define LSCD_ST_ACT_A      0
`define LSCD_ST_ACT_B      1
`define LSCD_ST_CLK_A      2
`define LSCD_ST_CLK_B      3
`define LSCD_ST_PRE_A      4
`define LSCD_ST_PRE_B      5

`endif

// [lscd_pkg.sv]
// types and shared decoders for the status pin clock dividers
// assumes lscd_defs.svh sits in the include path
`include "lscd_defs.svh"

package lscd_pkg;

	// one status pin as driven toward the pad
	typedef struct packed {
		logic level;
		logic drive;
		logic slow;
	} lscd_pin_t;

	// neighbouring control register layout
	typedef struct packed {
		logic [1:0] pre_b;
		logic [1:0] pre_a;
		logic [1:0] mux_b;
		logic [1:0] mux_a;
	} lscd_ctrl_t;

	// ratio code to divide ratio, zero means stopped
	function automatic logic [8:0] lscd_ratio(input logic [7:0] code);
		if (code == `LSCD_CODE_OFF)
			return `LSCD_RATIO_OFF;
		else if (code <= `LSCD_CODE_SHORT)
			return `LSCD_RATIO_MIN;
		else
			return {1'b0, code} + 9'h001;
	endfunction : lscd_ratio

	// prescale select to length, zero means stopped
	function automatic logic [2:0] lscd_prescale(input logic [1:0] sel);
		case (sel)
			`LSCD_PRE_DIV4: return `LSCD_PRE_LEN4;
			`LSCD_PRE_DIV5: return `LSCD_PRE_LEN5;
			default:        return `LSCD_PRE_LEN0;
		endcase
	endfunction : lscd_prescale

endpackage : lscd_pkg

// [lscd_divider.sv]
// one programmable status divider counting input ticks
// assumes tick_i is a one-cycle pulse per input clock period
`timescale 1ns/1ns
`include "lscd_defs.svh"

module lscd_divider (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// control
	input  wire logic [7:0] code_i,
	input  wire logic       restart_i,
	input  wire logic       tick_i,
	// result
	output logic            clk_o,
	output logic            active_o
);

	logic [8:0] cnt_reg;
	logic [8:0] cnt_next;
	logic [8:0] ratio_reg;
	logic [8:0] ratio_next;
	logic       out_reg;
	logic       out_next;
	logic [8:0] ratio_now;

	always_comb begin
		ratio_now  = lscd_pkg::lscd_ratio(code_i);
		cnt_next   = cnt_reg;
		ratio_next = ratio_reg;
		out_next   = out_reg;
		if (ratio_now == `LSCD_RATIO_OFF) begin
			// code zero stops the output low at once
			cnt_next   = `LSCD_RATIO_OFF;
			ratio_next = `LSCD_RATIO_OFF;
			out_next   = 1'b0;
		end else if (restart_i || ratio_reg == `LSCD_RATIO_OFF) begin
			cnt_next   = `LSCD_RATIO_OFF;
			ratio_next = ratio_now;
			out_next   = 1'b1;
		end else if (tick_i) begin
			if (cnt_reg == ratio_reg - 9'h001) begin
				// new ratio only at a period edge, no runt pulse
				cnt_next   = `LSCD_RATIO_OFF;
				ratio_next = ratio_now;
				out_next   = 1'b1;
			end else begin
				cnt_next = cnt_reg + 9'h001;
				out_next = (cnt_next < (ratio_reg >> 1));
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg   <= `LSCD_RATIO_OFF;
			ratio_reg <= `LSCD_RATIO_OFF;
			out_reg   <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			ratio_reg <= ratio_next;
			out_reg   <= out_next;
		end
	end

	assign clk_o    = out_reg;
	assign active_o = (ratio_reg != `LSCD_RATIO_OFF);

endmodule : lscd_divider

// [lscd_top_props.sv]
// assertions on the ports of the status pin divider block
// assumes a bind to lscd_top, one clock, and the defs header in path
`timescale 1ns/1ns
`include "lscd_defs.svh"
module lscd_top_props (
	// clock and reset
	input wire logic                clk_i,
	input wire logic                sys_rst_i,
	// register port
	input wire logic [7:0]          addr_i,
	input wire logic [7:0]          wdata_i,
	input wire logic                wr_i,
	input wire logic                rd_i,
	input wire logic [7:0]          rdata_o,
	// normal status level of pin a
	input wire logic                status_a_normal_i,
	// status pins
	input wire lscd_pkg::lscd_pin_t status_pin_a_o,
	input wire lscd_pkg::lscd_pin_t status_pin_b_o
);
	logic [7:0] ctl_reg, ctl_next, da_reg, da_next, db_reg, db_next;
	logic [3:0] sl_reg, sl_next;

	// shadow of what software wrote, so reads can be tied to writes
	always_comb begin
		ctl_next = ctl_reg;
		da_next  = da_reg;
		db_next  = db_reg;
		sl_next  = sl_reg;
		if (wr_i && addr_i == `LSCD_ADDR_CTRL) ctl_next = wdata_i;
		if (wr_i && addr_i == `LSCD_ADDR_DIVA) da_next = wdata_i;
		if (wr_i && addr_i == `LSCD_ADDR_DIVB) db_next = wdata_i;
		if (wr_i && addr_i == `LSCD_ADDR_SLEW) sl_next = wdata_i[3:0];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl_reg <= `LSCD_CTRL_RST;
			da_reg  <= `LSCD_DIV_RST;
			db_reg  <= `LSCD_DIV_RST;
			sl_reg  <= `LSCD_SLEW_RST;
		end else begin
			ctl_reg <= ctl_next;
			da_reg  <= da_next;
			db_reg  <= db_next;
			sl_reg  <= sl_next;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_ctl_wr;
		wr_i && addr_i == `LSCD_ADDR_CTRL;
	endsequence
	// three settled cycles cover the divider and pin register lag
	sequence s_stop_a;
		(ctl_reg[1:0] == `LSCD_MUX_DIVA && da_reg == 8'h00)[*3];
	endsequence
	sequence s_stop_b;
		(ctl_reg[3:2] == `LSCD_MUX_DIVB && db_reg == 8'h00)[*3];
	endsequence

	a_div_a_read: assert property (
		rd_i && addr_i == `LSCD_ADDR_DIVA |=> rdata_o == da_reg)
		else $error("divider a code reads back wrong");
	a_div_b_read: assert property (
		rd_i && addr_i == `LSCD_ADDR_DIVB |=> rdata_o == db_reg)
		else $error("divider b code reads back wrong");
	a_slew_read: assert property (
		rd_i && addr_i == `LSCD_ADDR_SLEW |=> rdata_o == {4'h0, sl_reg})
		else $error("edge rate register reads back wrong");
	a_stop_a_low: assert property (
		s_stop_a |-> !status_pin_a_o.level)
		else $error("stopped divider a still toggles pin a");
	a_stop_b_low: assert property (
		s_stop_b |-> !status_pin_b_o.level)
		else $error("stopped divider b still toggles pin b");
	a_slew_pin_a: assert property (
		$stable(sl_reg)[*3] |->
		status_pin_a_o.slow == (sl_reg[1:0] == `LSCD_SLEW_SLOW))
		else $error("pin a edge rate does not follow field");
	a_slew_pin_b: assert property (
		$stable(sl_reg)[*3] |->
		status_pin_b_o.slow == (sl_reg[3:2] == `LSCD_SLEW_SLOW))
		else $error("pin b edge rate does not follow field");
	a_pin_a_off: assert property (
		s_ctl_wr ##0 wdata_i[1:0] == `LSCD_MUX_OFF
		|-> ##[1:3] !status_pin_a_o.drive)
		else $error("pin a still driven after source off");
	a_pin_b_on: assert property (
		s_ctl_wr ##0 wdata_i[3:2] != `LSCD_MUX_OFF
		|-> ##[1:3] status_pin_b_o.drive)
		else $error("pin b not driven for an active source");
	a_norm_pin_a: assert property (
		!$past(sys_rst_i) && $past(ctl_reg[1:0]) == `LSCD_MUX_NORM
		|-> status_pin_a_o.level == $past(status_a_normal_i))
		else $error("pin a does not follow its normal status level");
endmodule : lscd_top_props

bind lscd_top lscd_top_props i_lscd_top_props (
	.clk_i          (clk_i),
	.sys_rst_i      (sys_rst_i),
	.addr_i         (addr_i),
	.wdata_i        (wdata_i),
	.wr_i           (wr_i),
	.rd_i           (rd_i),
	.rdata_o        (rdata_o),
	.status_a_normal_i (status_a_normal_i),
	.status_pin_a_o (status_pin_a_o),
	.status_pin_b_o (status_pin_b_o)
);

// [tb_lscd_top.sv]
// self-checking bench for the status pin divider block
// assumes lscd_pkg, lscd_top and its checker are compiled first
`timescale 1ns/1ns
`include "lscd_defs.svh"
module tb_lscd_top;
	logic                clk_i = 1'b0;
	logic                sys_rst_i = 1'b1;
	logic [7:0]          addr_i = 8'h00;
	logic [7:0]          wdata_i = 8'h00;
	logic                wr_i = 1'b0;
	logic                rd_i = 1'b0;
	logic [7:0]          rdata_o;
	logic                pll_a = 1'b0;
	logic                pll_b = 1'b0;
	logic                norm_a = 1'b0;
	logic                norm_b = 1'b0;
	lscd_pkg::lscd_pin_t pin_a;
	lscd_pkg::lscd_pin_t pin_b;
	logic [7:0]          rq[$];
	int                  pq[$];
	int                  n_mismatch = 0;
	int                  compares = 0;
	int                  cyc = 0;
	int                  last = -1;
	logic                arm = 1'b0;
	logic                rd_q = 1'b0;
	logic                lvl_q = 1'b0;
	logic [7:0]          v;
	localparam logic [7:0] RA [6] = '{`LSCD_ADDR_CTRL, `LSCD_ADDR_DIVA,
		`LSCD_ADDR_DIVB, `LSCD_ADDR_SLEW, `LSCD_ADDR_RESTART, 8'h50};
	localparam logic [7:0] RE [6] = '{`LSCD_CTRL_RST, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};

	lscd_top i_lscd_top (
		.clk_i             (clk_i),
		.sys_rst_i         (sys_rst_i),
		.addr_i            (addr_i),
		.wdata_i           (wdata_i),
		.wr_i              (wr_i),
		.rd_i              (rd_i),
		.rdata_o           (rdata_o),
		.first_pll_clk_i   (pll_a),
		.second_pll_clk_i  (pll_b),
		.status_a_normal_i (norm_a),
		.status_b_normal_i (norm_b),
		.status_pin_a_o    (pin_a),
		.status_pin_b_o    (pin_b)
	);

	initial begin
		forever #10 clk_i = ~clk_i;
	end

	// pll clocks of 4 and 6 cycles keep every period exact in clk_i
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc % 2 == 1) pll_a <= ~pll_a;
		if (cyc % 3 == 2) pll_b <= ~pll_b;
		norm_a <= 1'($urandom);
		norm_b <= 1'($urandom);
	end

	task automatic chk_rd(input logic [7:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: read %h want %h", $time, got, exp);
		end
	endtask : chk_rd

	task automatic chk_per(input int got, exp);
		compares++;
		if (got != exp) begin
			n_mismatch++;
			$display("wrong value at %0t: period %0d want %0d", $time, got, exp);
		end
	endtask : chk_per

	always @(posedge clk_i) begin
		rd_q  <= rd_i;
		lvl_q <= pin_a.level;
		if (rd_q)
			chk_rd(rdata_o, rq.pop_front());
		if (arm && pin_a.level && !lvl_q) begin
			if (last >= 0 && pq.size() > 0)
				chk_per(cyc - last, pq.pop_front());
			last <= cyc;
		end
	end

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i);
		rq.push_back(e);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
	endtask : rd

	function automatic int ratio(input logic [7:0] c);
		return (c == 8'h00) ? 0 : (c < 8'h06) ? 6 : int'(c) + 1;
	endfunction : ratio

	// b picks divider b routed to pin a, else divider a on pin a
	task automatic per(input logic b, input logic [1:0] ps,
		input logic [7:0] c);
		int n;
		n = ratio(c) * (ps == `LSCD_PRE_DIV4 ? 4 : 5) * (b ? 6 : 4);
		wr(`LSCD_ADDR_CTRL, b ? {ps, 6'h09} : {2'h0, ps, 4'h8});
		wr(b ? `LSCD_ADDR_DIVB : `LSCD_ADDR_DIVA, c);
		wr(`LSCD_ADDR_RESTART, 8'h03);
		repeat (n) @(posedge clk_i);
		last <= -1;
		arm  <= 1'b1;
		pq.push_back(n);
		pq.push_back(n);
		for (int i = 0; i < 4 * n && pq.size() > 0; i++)
			@(posedge clk_i);
		arm <= 1'b0;
		if (pq.size() > 0) begin
			n_mismatch++;
			$display("wrong value at %0t: pin a period missing", $time);
			pq.delete();
		end
	endtask : per

	task automatic final_report();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	initial begin
		#2000000;
		n_mismatch++;
		final_report();
	end

	initial begin
		void'($urandom(44));
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		wr(8'h50, 8'hff);
		for (int i = 0; i < 6; i++) rd(RA[i], RE[i]);
		wr(`LSCD_ADDR_CTRL, 8'h0b);
		repeat (8) begin
			v = 8'($urandom);
			wr(`LSCD_ADDR_CTRL, v);
			rd(`LSCD_ADDR_CTRL, v);
			wr(`LSCD_ADDR_SLEW, v & 8'hfa);
			rd(`LSCD_ADDR_SLEW, v & 8'h0a);
		end
		for (int c = 0; c < 4; c++) begin
			wr(`LSCD_ADDR_CTRL, {c[1:0], c[1:0], 4'h4});
			repeat (4) @(posedge clk_i);
			rd(`LSCD_ADDR_STATE, {2'h0, {2{c == 1 || c == 2}}, 4'h0});
		end
		per(1'b0, `LSCD_PRE_DIV4, 8'h01);
		per(1'b0, `LSCD_PRE_DIV5, 8'h05);
		per(1'b0, `LSCD_PRE_DIV4, 8'h06);
		per(1'b0, `LSCD_PRE_DIV5, 8'h07);
		per(1'b0, `LSCD_PRE_DIV5, 8'hff);
		per(1'b1, `LSCD_PRE_DIV4, 8'h03);
		per(1'b1, `LSCD_PRE_DIV5, 8'($urandom_range(255, 6)));
		wr(`LSCD_ADDR_DIVA, 8'h00);
		wr(`LSCD_ADDR_DIVB, 8'h00);
		wr(`LSCD_ADDR_CTRL, 8'h54);
		repeat (8) @(posedge clk_i);
		rd(`LSCD_ADDR_STATE, 8'h30);
		repeat (4) @(posedge clk_i);
		final_report();
	end
endmodule : tb_lscd_top
